// file: dcsm_core_model.sv
// Bus master model of one core on the block's register port.
`timescale 1ns/100ps
module dcsm_core_model (
  input wire logic clk,
  output logic [11:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  // ==========================================================
  // Idle bus at time zero.
  initial begin
    addr = 12'h000;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ==========================================================
  // One strobe cycle, then a gap cycle, so a strobe is never lowered
  // and raised again in one time step.
  task automatic write(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // Released data is inverted so nothing stale is trusted.
    @(posedge clk);
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic read(input logic [11:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
endmodule

// file: dcsm_pkg.sv
// Package of register offsets, field positions and reset values.
package dcsm_pkg;
  // ==========================================================
  // Register offsets (byte addresses).
  localparam logic [11:0] OFS_LOCK_0 = 12'h000;
  localparam logic [11:0] OFS_LOCK_1 = 12'h004;
  localparam logic [11:0] OFS_LOCK_2 = 12'h008;
  localparam logic [11:0] OFS_LOCK_3 = 12'h00c;
  localparam logic [11:0] OFS_LOCK_4 = 12'h010;
  localparam logic [11:0] OFS_LOCK_5 = 12'h014;
  localparam logic [11:0] OFS_LOCK_6 = 12'h018;
  localparam logic [11:0] OFS_LOCK_7 = 12'h020;
  localparam logic [11:0] OFS_PRI_BELL = 12'h040;
  localparam logic [11:0] OFS_MAIL_0 = 12'h044;
  localparam logic [11:0] OFS_SEC_BELL = 12'h048;
  localparam logic [11:0] OFS_MAIL_1 = 12'h04c;
  localparam logic [11:0] OFS_MIRROR = 12'h100;
  // ==========================================================
  // Field positions and reset values.
  localparam int LOCK_COUNT = 8;
  localparam int LOCK_BIT = 0;
  localparam int BELL_REQ_BIT = 16;
  localparam int BELL_EN_BIT = 0;
  localparam logic [7:0] LOCK_RESET = 8'h00;
  localparam logic [31:0] MAIL_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage

// file: dcsm_top.sv
// Semaphore and mailbox block shared by a primary and a secondary core.
// Operation
// - Eight independent one-bit semaphores, each in its own register.
// - Reading a semaphore returns its value and sets it if it was 0.
// - Writing 0 to a semaphore clears it, but a same-cycle read of it by the other core leaves it set; 1 is taken, 0 is free.
// - Semaphore flag in bit 0; bits 31:1 read 0 and reset to 0.
// - A status register continuously reflects all eight semaphore flags.
// - Status bit n mirrors semaphore n; reading status alters nothing.
// - Two 32-bit mailbox words, readable and writable by both cores.
// - Primary interrupt is high while its request and enable bits are 1.
// - Secondary interrupt is high while its request and enable bits are 1.
// - Either core may write either doorbell register.
// - Primary doorbell: request bit 16, enable bit 0, others reserved.
// - Secondary doorbell: request bit 16, enable bit 0, others reserved.
// - Block soft reset returns the whole block to its reset state.
// - All fields reset on system reset and on block soft reset.
// - Registers sit at the fixed offsets of the register map.
`timescale 1ns/100ps
module dcsm_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic block_soft_reset,
  // Primary core port.
  input wire logic [11:0] p_addr,
  input wire logic [31:0] p_wdata,
  input wire logic p_wr,
  input wire logic p_rd,
  output logic [31:0] p_rdata,
  // Secondary core port.
  input wire logic [11:0] s_addr,
  input wire logic [31:0] s_wdata,
  input wire logic s_wr,
  input wire logic s_rd,
  output logic [31:0] s_rdata,
  output logic primary_core_irq,
  output logic secondary_core_irq
);

  // ==========================================================
  // Reset combination.
  // Both the system reset and the block soft reset clear every field.
  wire logic clr;
  assign clr = !rstn || block_soft_reset;

  // ==========================================================
  // State.
  logic [7:0] lock_reg;
  logic [7:0] lock_next;
  logic primary_core_request_reg;
  logic primary_en_reg;
  logic secondary_core_request_reg;
  logic secondary_en_reg;
  logic [31:0] mail0_reg;
  logic [31:0] mail1_reg;

  // ==========================================================
  // Address decode for each port.
  function automatic logic [3:0] lock_index(input logic [11:0] a);
    unique case (a)
      dcsm_pkg::OFS_LOCK_0: lock_index = 4'h0;
      dcsm_pkg::OFS_LOCK_1: lock_index = 4'h1;
      dcsm_pkg::OFS_LOCK_2: lock_index = 4'h2;
      dcsm_pkg::OFS_LOCK_3: lock_index = 4'h3;
      dcsm_pkg::OFS_LOCK_4: lock_index = 4'h4;
      dcsm_pkg::OFS_LOCK_5: lock_index = 4'h5;
      dcsm_pkg::OFS_LOCK_6: lock_index = 4'h6;
      dcsm_pkg::OFS_LOCK_7: lock_index = 4'h7;
      default: lock_index = 4'h8;
    endcase
  endfunction

  wire logic [3:0] p_idx;
  wire logic [3:0] s_idx;
  assign p_idx = lock_index(p_addr);
  assign s_idx = lock_index(s_addr);
  wire logic p_hit_lock;
  wire logic s_hit_lock;
  assign p_hit_lock = !p_idx[3];
  assign s_hit_lock = !s_idx[3];
  wire logic [2:0] p_sel;
  wire logic [2:0] s_sel;
  assign p_sel = p_idx[2:0];
  assign s_sel = s_idx[2:0];

  // ==========================================================
  // Semaphore next state.
  // The primary port is served first within a cycle, so a same-cycle read
  // of one free flag by both ports lets only the primary claim it.
  always_comb begin
    lock_next = lock_reg;
    if (p_wr && p_hit_lock && !p_wdata[dcsm_pkg::LOCK_BIT]) begin
      lock_next[p_sel] = 1'b0;
    end
    if (s_wr && s_hit_lock && !s_wdata[dcsm_pkg::LOCK_BIT]) begin
      lock_next[s_sel] = 1'b0;
    end
    if (p_rd && p_hit_lock) begin
      lock_next[p_sel] = 1'b1;
    end
    if (s_rd && s_hit_lock) begin
      lock_next[s_sel] = 1'b1;
    end
  end

  // Secondary sees the flag as the primary read left it.
  wire logic s_seen;
  assign s_seen = lock_reg[s_sel] ||
    (p_rd && p_hit_lock && p_sel == s_sel);

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      lock_reg <= dcsm_pkg::LOCK_RESET;
    end else begin
      lock_reg <= lock_next;
    end
  end

  // ==========================================================
  // Doorbells and mailboxes; secondary write wins over a same-cycle
  // primary write, software is expected to avoid that case.
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      primary_core_request_reg <= 1'b0;
      primary_en_reg <= 1'b0;
      secondary_core_request_reg <= 1'b0;
      secondary_en_reg <= 1'b0;
      mail0_reg <= dcsm_pkg::MAIL_RESET;
      mail1_reg <= dcsm_pkg::MAIL_RESET;
    end else begin
      if (p_wr && p_addr == dcsm_pkg::OFS_PRI_BELL) begin
        primary_core_request_reg <= p_wdata[dcsm_pkg::BELL_REQ_BIT];
        primary_en_reg <= p_wdata[dcsm_pkg::BELL_EN_BIT];
      end
      if (s_wr && s_addr == dcsm_pkg::OFS_PRI_BELL) begin
        primary_core_request_reg <= s_wdata[dcsm_pkg::BELL_REQ_BIT];
        primary_en_reg <= s_wdata[dcsm_pkg::BELL_EN_BIT];
      end
      if (p_wr && p_addr == dcsm_pkg::OFS_SEC_BELL) begin
        secondary_core_request_reg <= p_wdata[dcsm_pkg::BELL_REQ_BIT];
        secondary_en_reg <= p_wdata[dcsm_pkg::BELL_EN_BIT];
      end
      if (s_wr && s_addr == dcsm_pkg::OFS_SEC_BELL) begin
        secondary_core_request_reg <= s_wdata[dcsm_pkg::BELL_REQ_BIT];
        secondary_en_reg <= s_wdata[dcsm_pkg::BELL_EN_BIT];
      end
      if (p_wr && p_addr == dcsm_pkg::OFS_MAIL_0) begin
        mail0_reg <= p_wdata;
      end
      if (s_wr && s_addr == dcsm_pkg::OFS_MAIL_0) begin
        mail0_reg <= s_wdata;
      end
      if (p_wr && p_addr == dcsm_pkg::OFS_MAIL_1) begin
        mail1_reg <= p_wdata;
      end
      if (s_wr && s_addr == dcsm_pkg::OFS_MAIL_1) begin
        mail1_reg <= s_wdata;
      end
    end
  end

  // ==========================================================
  // Read data, with the interrupts registered from the next state.
  function automatic logic [31:0] read_mux(input logic [11:0] a,
                                           input logic hit,
                                           input logic flag,
                                           input logic [7:0] locks,
                                           input logic [31:0] m0,
                                           input logic [31:0] m1,
                                           input logic pr, input logic pe,
                                           input logic sr, input logic se);
    logic [31:0] v;
    v = dcsm_pkg::READ_ZERO;
    if (hit) begin
      v[dcsm_pkg::LOCK_BIT] = flag;
    end else begin
      unique case (a)
        dcsm_pkg::OFS_PRI_BELL: begin
          v[dcsm_pkg::BELL_REQ_BIT] = pr;
          v[dcsm_pkg::BELL_EN_BIT] = pe;
        end
        dcsm_pkg::OFS_SEC_BELL: begin
          v[dcsm_pkg::BELL_REQ_BIT] = sr;
          v[dcsm_pkg::BELL_EN_BIT] = se;
        end
        dcsm_pkg::OFS_MAIL_0: v = m0;
        dcsm_pkg::OFS_MAIL_1: v = m1;
        dcsm_pkg::OFS_MIRROR: v[7:0] = locks;
        default: v = dcsm_pkg::READ_ZERO;
      endcase
    end
    read_mux = v;
  endfunction

  wire logic [31:0] p_rd_val;
  wire logic [31:0] s_rd_val;
  assign p_rd_val = read_mux(p_addr, p_hit_lock, lock_reg[p_sel], lock_reg,
    mail0_reg, mail1_reg, primary_core_request_reg, primary_en_reg,
    secondary_core_request_reg, secondary_en_reg);
  assign s_rd_val = read_mux(s_addr, s_hit_lock, s_seen, lock_reg,
    mail0_reg, mail1_reg, primary_core_request_reg, primary_en_reg,
    secondary_core_request_reg, secondary_en_reg);

  // The interrupt flops sample the next bell values so the output is one
  // flop deep yet follows the bell register in the same edge.
  wire logic pri_irq_next;
  wire logic sec_irq_next;
  logic pr_n;
  logic pe_n;
  logic sr_n;
  logic se_n;
  always_comb begin
    pr_n = primary_core_request_reg;
    pe_n = primary_en_reg;
    sr_n = secondary_core_request_reg;
    se_n = secondary_en_reg;
    if (p_wr && p_addr == dcsm_pkg::OFS_PRI_BELL) begin
      pr_n = p_wdata[dcsm_pkg::BELL_REQ_BIT];
      pe_n = p_wdata[dcsm_pkg::BELL_EN_BIT];
    end
    if (s_wr && s_addr == dcsm_pkg::OFS_PRI_BELL) begin
      pr_n = s_wdata[dcsm_pkg::BELL_REQ_BIT];
      pe_n = s_wdata[dcsm_pkg::BELL_EN_BIT];
    end
    if (p_wr && p_addr == dcsm_pkg::OFS_SEC_BELL) begin
      sr_n = p_wdata[dcsm_pkg::BELL_REQ_BIT];
      se_n = p_wdata[dcsm_pkg::BELL_EN_BIT];
    end
    if (s_wr && s_addr == dcsm_pkg::OFS_SEC_BELL) begin
      sr_n = s_wdata[dcsm_pkg::BELL_REQ_BIT];
      se_n = s_wdata[dcsm_pkg::BELL_EN_BIT];
    end
  end
  assign pri_irq_next = pr_n && pe_n;
  assign sec_irq_next = sr_n && se_n;

  always_ff @(posedge ref_clk) begin
    if (clr) begin
      p_rdata <= dcsm_pkg::READ_ZERO;
      s_rdata <= dcsm_pkg::READ_ZERO;
      primary_core_irq <= 1'b0;
      secondary_core_irq <= 1'b0;
    end else begin
      p_rdata <= p_rd ? p_rd_val : dcsm_pkg::READ_ZERO;
      s_rdata <= s_rd ? s_rd_val : dcsm_pkg::READ_ZERO;
      primary_core_irq <= pri_irq_next;
      secondary_core_irq <= sec_irq_next;
    end
  end

  // ==========================================================
  // Checks.
  // Hold checks also demand no reset at their first edge: a reset lowered
  // just after its edge is no longer seen by disable iff at that edge.
  sequence seq_p_claim_free;
    !clr && p_rd && p_hit_lock && !lock_reg[p_sel];
  endsequence
  sequence seq_p_claim_answer;
    p_rdata == dcsm_pkg::READ_ZERO && lock_reg[$past(p_sel)];
  endsequence
  sequence seq_s_claim_free;
    !clr && s_rd && s_hit_lock && !lock_reg[s_sel]
      && !(p_rd && p_hit_lock && p_sel == s_sel);
  endsequence
  sequence seq_s_claim_answer;
    s_rdata == dcsm_pkg::READ_ZERO && lock_reg[$past(s_sel)];
  endsequence
  sequence seq_both_claim;
    !clr && p_rd && s_rd && p_hit_lock && p_addr == s_addr
      && !lock_reg[p_sel];
  endsequence
  sequence seq_no_access;
    !clr && !p_rd && !p_wr && !s_rd && !s_wr;
  endsequence
  sequence seq_no_write;
    !clr && !p_wr && !s_wr;
  endsequence

  // Semaphore claim, release and hold.
  AST_CLAIM_FREE: assert property (@(posedge ref_clk)
    disable iff (clr) seq_p_claim_free |=> seq_p_claim_answer)
    else $error("Primary claim failed.");
  AST_SEC_CLAIM: assert property (@(posedge ref_clk)
    disable iff (clr) seq_s_claim_free |=> seq_s_claim_answer)
    else $error("Secondary claim failed.");
  AST_RACE_ONE: assert property (@(posedge ref_clk)
    disable iff (clr) seq_both_claim
      |=> !p_rdata[dcsm_pkg::LOCK_BIT] && s_rdata[dcsm_pkg::LOCK_BIT])
    else $error("Both cores claimed one semaphore.");
  AST_CLEAR_ZERO: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_wr && p_hit_lock && !p_wdata[dcsm_pkg::LOCK_BIT]
      && !(s_rd && s_addr == p_addr)
      |=> !lock_reg[$past(p_sel)])
    else $error("Semaphore not cleared.");
  AST_WRITE_ONE: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_wr && p_hit_lock && p_wdata[dcsm_pkg::LOCK_BIT]
      && !s_wr && !s_rd && !p_rd
      |=> lock_reg == $past(lock_reg))
    else $error("Write of one changed a semaphore.");
  AST_RESV_ZERO: assert property (@(posedge ref_clk)
    disable iff (clr) p_rd && p_hit_lock |=> p_rdata[31:1] == 31'h0)
    else $error("Reserved semaphore bits not zero.");
  AST_LOCK_HOLD: assert property (@(posedge ref_clk)
    disable iff (clr) seq_no_access |=> lock_reg == $past(lock_reg))
    else $error("Semaphore changed with no access.");

  // Status mirror, on both ports.
  AST_MIRROR_READ: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_rd && p_addr == dcsm_pkg::OFS_MIRROR && !s_rd && !s_wr && !p_wr
      |=> p_rdata == {24'h000000, $past(lock_reg)}
      && lock_reg == $past(lock_reg))
    else $error("Mirror read wrong or disturbing.");
  AST_MIRROR_SEC: assert property (@(posedge ref_clk)
    disable iff (clr) s_rd && s_addr == dcsm_pkg::OFS_MIRROR
      |=> s_rdata == {24'h000000, $past(lock_reg)})
    else $error("Secondary mirror read wrong.");

  // Doorbells and interrupts. The one-edge history is skipped right after
  // a reset edge, where the flops were cleared instead of loaded.
  AST_PRI_IRQ: assert property (@(posedge ref_clk)
    disable iff (clr)
    primary_core_irq == (primary_core_request_reg && primary_en_reg)
      && ($past(clr) || primary_core_irq == $past(pri_irq_next)))
    else $error("Primary interrupt mismatch.");
  AST_SEC_IRQ_LVL: assert property (@(posedge ref_clk)
    disable iff (clr)
    secondary_core_irq == (secondary_core_request_reg && secondary_en_reg)
      && ($past(clr) || secondary_core_irq == $past(sec_irq_next)))
    else $error("Secondary interrupt level mismatch.");
  AST_SEC_IRQ: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_wr && p_addr == dcsm_pkg::OFS_SEC_BELL && !s_wr
      |=> secondary_core_irq == ($past(p_wdata[dcsm_pkg::BELL_REQ_BIT])
      && $past(p_wdata[dcsm_pkg::BELL_EN_BIT])))
    else $error("Secondary interrupt mismatch.");
  AST_PRI_BELL_WR: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_wr && p_addr == dcsm_pkg::OFS_PRI_BELL && !s_wr
      |=> primary_core_request_reg == $past(p_wdata[dcsm_pkg::BELL_REQ_BIT])
      && primary_en_reg == $past(p_wdata[dcsm_pkg::BELL_EN_BIT]))
    else $error("Primary doorbell write lost.");
  AST_SEC_BELL_WR: assert property (@(posedge ref_clk)
    disable iff (clr)
    s_wr && s_addr == dcsm_pkg::OFS_SEC_BELL
      |=> secondary_core_request_reg == $past(s_wdata[dcsm_pkg::BELL_REQ_BIT])
      && secondary_en_reg == $past(s_wdata[dcsm_pkg::BELL_EN_BIT]))
    else $error("Secondary doorbell write lost.");
  AST_BELL_READ: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_rd && p_addr == dcsm_pkg::OFS_PRI_BELL
      |=> p_rdata[dcsm_pkg::BELL_REQ_BIT] == $past(primary_core_request_reg)
      && p_rdata[dcsm_pkg::BELL_EN_BIT] == $past(primary_en_reg))
    else $error("Primary doorbell read wrong.");

  // Mailboxes.
  AST_MAIL_KEEP: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_wr && p_addr == dcsm_pkg::OFS_MAIL_1 && !s_wr
      |=> mail1_reg == $past(p_wdata))
    else $error("Mailbox write lost.");
  AST_MAIL0_KEEP: assert property (@(posedge ref_clk)
    disable iff (clr)
    p_wr && p_addr == dcsm_pkg::OFS_MAIL_0 && !s_wr
      |=> mail0_reg == $past(p_wdata))
    else $error("Mailbox zero write lost.");
  AST_MAIL_SEC: assert property (@(posedge ref_clk)
    disable iff (clr)
    s_wr && s_addr == dcsm_pkg::OFS_MAIL_1
      |=> mail1_reg == $past(s_wdata))
    else $error("Secondary mailbox write lost.");
  AST_MAIL_HOLD: assert property (@(posedge ref_clk)
    disable iff (clr) seq_no_write
      |=> mail0_reg == $past(mail0_reg) && mail1_reg == $past(mail1_reg))
    else $error("Mailbox changed with no write.");

  // Resets; these run without disable iff since they watch the reset.
  AST_RESET: assert property (@(posedge ref_clk)
    block_soft_reset |=> lock_reg == dcsm_pkg::LOCK_RESET
      && mail0_reg == dcsm_pkg::MAIL_RESET
      && mail1_reg == dcsm_pkg::MAIL_RESET
      && !primary_core_irq && !secondary_core_irq)
    else $error("Soft reset incomplete.");
  AST_SYS_RESET: assert property (@(posedge ref_clk)
    !rstn |=> lock_reg == dcsm_pkg::LOCK_RESET
      && mail1_reg == dcsm_pkg::MAIL_RESET
      && p_rdata == dcsm_pkg::READ_ZERO && s_rdata == dcsm_pkg::READ_ZERO
      && !primary_core_irq && !secondary_core_irq)
    else $error("System reset incomplete.");
endmodule

// file: tb_dcsm_top.sv
// Self-checking bench for the semaphore and mailbox block.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_dcsm_top;
  localparam logic [11:0] LK [8] = '{dcsm_pkg::OFS_LOCK_0,
    dcsm_pkg::OFS_LOCK_1, dcsm_pkg::OFS_LOCK_2, dcsm_pkg::OFS_LOCK_3,
    dcsm_pkg::OFS_LOCK_4, dcsm_pkg::OFS_LOCK_5, dcsm_pkg::OFS_LOCK_6,
    dcsm_pkg::OFS_LOCK_7};
  localparam logic [11:0] BP = dcsm_pkg::OFS_PRI_BELL;
  localparam logic [11:0] BS = dcsm_pkg::OFS_SEC_BELL;
  localparam logic [11:0] MB0 = dcsm_pkg::OFS_MAIL_0;
  localparam logic [11:0] MB1 = dcsm_pkg::OFS_MAIL_1;
  localparam logic [11:0] MIR = dcsm_pkg::OFS_MIRROR;
  logic ref_clk;
  logic rstn;
  logic block_soft_reset;
  logic [11:0] p_addr, s_addr;
  logic [31:0] p_wdata, s_wdata, p_rdata, s_rdata;
  logic p_wr, p_rd, s_wr, s_rd, primary_core_irq, secondary_core_irq;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  // ==========================================================
  // Block under test and the two core models.
  dcsm_top u_dut (.ref_clk(ref_clk), .rstn(rstn),
    .block_soft_reset(block_soft_reset), .p_addr(p_addr),
    .p_wdata(p_wdata), .p_wr(p_wr), .p_rd(p_rd), .p_rdata(p_rdata),
    .s_addr(s_addr), .s_wdata(s_wdata), .s_wr(s_wr), .s_rd(s_rd),
    .s_rdata(s_rdata), .primary_core_irq(primary_core_irq),
    .secondary_core_irq(secondary_core_irq));
  dcsm_core_model u_pri (.clk(ref_clk), .addr(p_addr), .wdata(p_wdata),
    .wr(p_wr), .rd(p_rd), .rdata(p_rdata));
  dcsm_core_model u_sec (.clk(ref_clk), .addr(s_addr), .wdata(s_wdata),
    .wr(s_wr), .rd(s_rd), .rdata(s_rdata));
  // ==========================================================
  // Shared access and compare helpers.
  task automatic rd_chk(input bit sec, input logic [11:0] a,
                        input logic [31:0] e, input string nm);
    logic [31:0] d;
    if (sec) u_sec.read(a, d);
    else u_pri.read(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic wr_reg(input bit sec, input logic [11:0] a,
                        input logic [31:0] d);
    if (sec) u_sec.write(a, d);
    else u_pri.write(a, d);
  endtask
  task automatic irq_chk(input logic ep, input logic es);
    @(negedge ref_clk);
    `CHK("primary irq", ep, primary_core_irq)
    `CHK("secondary irq", es, secondary_core_irq)
    @(posedge ref_clk);
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_map();
    for (int i = 0; i < 8; i++) begin
      rd_chk(1'b0, LK[i], 32'h0, "lock reset");
      rd_chk(1'b1, MIR, (32'h2 << i) - 32'h1, "mirror");
    end
    rd_chk(1'b0, MIR, 32'hff, "mirror again");
    rd_chk(1'b1, LK[7], 32'h1, "lock taken");
    rd_chk(1'b0, 12'h01c, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      rd_chk(1'b1, BP + 12'(4 * i), 32'h0, "bell or mail reset");
    end
    for (int i = 0; i < 8; i++) begin
      wr_reg(1'b1, LK[i], 32'h0);
    end
    rd_chk(1'b0, MIR, 32'h0, "mirror released");
    $display("t_map done");
  endtask
  task automatic t_claim();
    rd_chk(1'b0, LK[3], 32'h0, "claim");
    rd_chk(1'b1, LK[3], 32'h1, "claim taken");
    wr_reg(1'b0, LK[3], 32'hffff_ffff);
    rd_chk(1'b1, MIR, 32'h08, "write one kept");
    wr_reg(1'b0, LK[3], 32'hffff_fffe);
    rd_chk(1'b1, LK[3], 32'h0, "reclaim");
    wr_reg(1'b1, LK[3], 32'h0);
    $display("t_claim done");
  endtask
  task automatic t_race();
    logic [31:0] dp, ds;
    fork
      u_pri.read(LK[5], dp);
      u_sec.read(LK[5], ds);
    join
    `CHK("race primary", 32'h0, dp)
    `CHK("race secondary", 32'h1, ds)
    wr_reg(1'b0, LK[5], 32'h0);
    $display("t_race done");
  endtask
  task automatic t_mail();
    wr_reg(1'b0, MB0, 32'ha5a5_5a5a);
    rd_chk(1'b1, MB0, 32'ha5a5_5a5a, "mail0");
    wr_reg(1'b1, MB1, 32'h0123_4567);
    rd_chk(1'b0, MB1, 32'h0123_4567, "mail1");
    wr_reg(1'b0, 12'h01c, 32'hffff_ffff);
    rd_chk(1'b1, MB0, 32'ha5a5_5a5a, "mail0 kept");
    $display("t_mail done");
  endtask
  task automatic t_bell();
    wr_reg(1'b1, BP, 32'h0001_0000);
    irq_chk(1'b0, 1'b0);
    wr_reg(1'b1, BP, 32'hffff_ffff);
    irq_chk(1'b1, 1'b0);
    rd_chk(1'b0, BP, 32'h0001_0001, "primary bell");
    wr_reg(1'b0, BP, 32'h0000_0001);
    irq_chk(1'b0, 1'b0);
    wr_reg(1'b0, BS, 32'hffff_ffff);
    irq_chk(1'b0, 1'b1);
    rd_chk(1'b1, BS, 32'h0001_0001, "secondary bell");
    wr_reg(1'b1, BS, 32'h0001_0000);
    irq_chk(1'b0, 1'b0);
    $display("t_bell done");
  endtask
  task automatic t_soft();
    rd_chk(1'b0, LK[2], 32'h0, "claim");
    wr_reg(1'b0, MB1, 32'hdead_beef);
    wr_reg(1'b0, BS, 32'h0001_0001);
    wr_reg(1'b1, BP, 32'h0001_0001);
    irq_chk(1'b1, 1'b1);
    block_soft_reset <= 1'b1;
    @(posedge ref_clk);
    block_soft_reset <= 1'b0;
    @(posedge ref_clk);
    irq_chk(1'b0, 1'b0);
    rd_chk(1'b0, MIR, 32'h0, "mirror soft");
    rd_chk(1'b1, MB1, 32'h0, "mail soft");
    rd_chk(1'b0, BP, 32'h0, "bell soft");
    rd_chk(1'b1, LK[6], 32'h0, "claim");
    rstn <= 1'b0;
    @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd_chk(1'b0, MIR, 32'h0, "mirror reset");
    $display("t_soft done");
  endtask
  // ==========================================================
  // Verdict; also reached when the cycle ceiling runs out.
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Free-running 40 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Cycle ceiling well above the roughly 150 cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  // Reset for two cycles, then the scenarios in turn.
  initial begin
    rstn = 1'b0;
    block_soft_reset = 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_map();
    t_claim();
    t_race();
    t_mail();
    t_bell();
    t_soft();
    wrap_up();
  end
endmodule
